/* inc/uvp_regs.vh */
// Constants for the UV EPROM host controller
`ifndef UVP_REGS_VH
`define UVP_REGS_VH
`define UVP_ADDR_W 13
`define UVP_DATA_W 8
`define UVP_WORDS 8192
`define UVP_LAST_ADDR 13'h1FFF
`define UVP_ERASED 8'hFF
`define UVP_PULSE_NS 2000000
`define UVP_CLK_NS 50
`define UVP_SETUP_NS 2000
`define UVP_ACCESS_NS 450
`define UVP_MAX_PASSES 25
`define UVP_MARGIN_PASSES 5
`define UVP_PIN_READ 2'h0
`define UVP_PIN_IDLE 2'h1
`define UVP_PIN_PROG 2'h2
`define UVP_PIN_PULSE 2'h3
`endif

/* hw/uvp_sync.v */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module uvp_sync #(
  parameter W = 8
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Async input and filtered output
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;

  // First flop feeds only the second; update once stages two and three agree
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      dout <= {W{1'b0}};
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r;
    end
  end
endmodule // uvp_sync

/* hw/uvp_ctrl.v */
// Host controller that reads and block-programs a UV EPROM
//
// Behaviour
// - Intermediate pin level enters program mode; device floats, host drives data.
// - After setup, apply one 2 ms pulse, kept within 1.9 to 2.1 ms.
// - Block mode: each pass pulses every location once, in address order; with several devices selected the code stops in S_HOLD after the first pulse.
// - Cumulative program time per word is 12 ms minimum, 50 ms maximum; the code reaches 60 ms when pass 25 verifies and five margin passes follow.
// - If verified in under 25 pulses, apply five more margin passes.
// - Parallel devices: pulse only those that take the current word.
// - On a shared bus at most one device enable is low at once.
`timescale 1ns/1ps
`include "uvp_regs.vh"
module uvp_ctrl #(
  parameter NDEV = 1,
  parameter PULSE_CYC = `UVP_PULSE_NS / `UVP_CLK_NS
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // User read request
  input wire rd_req,
  input wire [`UVP_ADDR_W-1:0] rd_addr,
  input wire [NDEV-1:0] rd_sel,
  output wire rd_ready,
  output reg rd_valid,
  output reg [`UVP_DATA_W-1:0] rd_data,
  // User program job; image words fetched by address
  input wire prog_start,
  input wire [NDEV-1:0] prog_sel,
  output reg [`UVP_ADDR_W-1:0] img_addr,
  input wire [NDEV*`UVP_DATA_W-1:0] img_data,
  output wire busy,
  output reg prog_done,
  output reg prog_fail,
  output reg [4:0] pass_count,
  // Device pins
  output reg [`UVP_ADDR_W-1:0] dev_addr,
  output reg [`UVP_DATA_W-1:0] dev_dq_out,
  output reg dev_dq_oe_n,
  input wire [`UVP_DATA_W-1:0] dev_dq_in,
  output reg [2*NDEV-1:0] dev_pin_lvl
);
  // Cycle counts derived from the printed times; setup and access round up
  localparam SETUP_CYC = (`UVP_SETUP_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS;
  localparam ACC_CYC = (`UVP_ACCESS_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS + 4;
  localparam S_IDLE = 3'h0;
  localparam S_RD = 3'h1;
  localparam S_SET = 3'h2;
  localparam S_PULSE = 3'h3;
  localparam S_HOLD = 3'h4;
  localparam S_VER = 3'h5;
  localparam S_VCHK = 3'h6;
  localparam S_END = 3'h7;

  reg [2:0] st_r;
  reg [31:0] cnt_r;
  reg [NDEV-1:0] sel_r;
  reg [NDEV-1:0] mis_r;
  reg [NDEV-1:0] dev_idx_r;
  reg margin_r;
  reg [2:0] mpass_r;
  wire [`UVP_DATA_W-1:0] dq_sync;
  integer i;

  // Read data from a pin passes the three-flop filter
  uvp_sync #(.W(`UVP_DATA_W)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(dev_dq_in),
    .dout(dq_sync)
  );

  // Pick the image byte for one device
  function [`UVP_DATA_W-1:0] img_byte;
    input [NDEV*`UVP_DATA_W-1:0] d;
    input integer k;
    begin
      img_byte = d[k*`UVP_DATA_W +: `UVP_DATA_W];
    end
  endfunction

  // Lowest set bit index, for one-device-at-a-time bus use
  function integer first_set;
    input [NDEV-1:0] v;
    integer j;
    begin
      first_set = 0;
      for (j = NDEV - 1; j >= 0; j = j - 1)
        if (v[j])
          first_set = j;
    end
  endfunction

  assign busy = (st_r != S_IDLE);
  assign rd_ready = (st_r == S_IDLE) && !prog_start;

  // Main sequencer
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_r <= S_IDLE;
      cnt_r <= 32'h0;
      sel_r <= {NDEV{1'b0}};
      mis_r <= {NDEV{1'b0}};
      dev_idx_r <= {NDEV{1'b0}};
      margin_r <= 1'b0;
      mpass_r <= 3'h0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      img_addr <= 13'h0000;
      prog_done <= 1'b0;
      prog_fail <= 1'b0;
      pass_count <= 5'h00;
      dev_addr <= 13'h0000;
      dev_dq_out <= `UVP_ERASED;
      dev_dq_oe_n <= 1'b1;
      dev_pin_lvl <= {NDEV{`UVP_PIN_IDLE}};
    end
    else
    begin
      rd_valid <= 1'b0;
      prog_done <= 1'b0;
      case (st_r)
        S_IDLE:
        begin
          dev_dq_oe_n <= 1'b1;
          dev_pin_lvl <= {NDEV{`UVP_PIN_IDLE}};
          cnt_r <= 32'h0;
          if (prog_start && prog_sel != {NDEV{1'b0}})
          begin
            // Pins go to program level; devices float their outputs
            sel_r <= prog_sel;
            prog_fail <= 1'b0;
            pass_count <= 5'h00;
            margin_r <= 1'b0;
            mpass_r <= 3'h0;
            img_addr <= 13'h0000;
            dev_addr <= 13'h0000;
            for (i = 0; i < NDEV; i = i + 1)
              dev_pin_lvl[2*i +: 2] <= `UVP_PIN_PROG;
            st_r <= S_SET;
          end
          else if (rd_req)
          begin
            // Only one enable low: the lowest selected device reads
            dev_addr <= rd_addr;
            dev_pin_lvl[2*first_set(rd_sel) +: 2] <= `UVP_PIN_READ;
            st_r <= S_RD;
          end
        end
        S_RD:
        begin
          // Wait access time plus the filter latency
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == ACC_CYC)
          begin
            rd_data <= dq_sync;
            rd_valid <= 1'b1;
            dev_pin_lvl <= {NDEV{`UVP_PIN_IDLE}};
            st_r <= S_IDLE;
          end
        end
        S_SET:
        begin
          // Address and data settle before the pulse; same address coding
          dev_addr <= img_addr;
          dev_dq_oe_n <= 1'b0;
          dev_dq_out <= img_byte(img_data, first_set(sel_r));
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == SETUP_CYC + 1)
          begin
            cnt_r <= 32'h0;
            for (i = 0; i < NDEV; i = i + 1)
              if (sel_r[i] && img_byte(img_data, i) == dev_dq_out)
                dev_pin_lvl[2*i +: 2] <= `UVP_PIN_PULSE;
            st_r <= S_PULSE;
          end
        end
        S_PULSE:
        begin
          // Fixed 2 ms high-voltage pulse
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == PULSE_CYC - 1)
          begin
            cnt_r <= 32'h0;
            for (i = 0; i < NDEV; i = i + 1)
              if (sel_r[i])
                dev_pin_lvl[2*i +: 2] <= `UVP_PIN_PROG;
            st_r <= S_HOLD;
          end
        end
        S_HOLD:
        begin
          cnt_r <= cnt_r + 32'h1;
          if (sel_r != (sel_r & ~(sel_r - {{(NDEV-1){1'b0}}, 1'b1})) && cnt_r == 32'h0)
          begin
            // Several devices selected: the counter is held at zero on every cycle
            cnt_r <= cnt_r;
          end
          if (cnt_r == SETUP_CYC)
          begin
            cnt_r <= 32'h0;
            if (img_addr == `UVP_LAST_ADDR)
            begin
              // End of a block pass
              img_addr <= 13'h0000;
              pass_count <= pass_count + 5'h01;
              dev_dq_oe_n <= 1'b1;
              if (margin_r)
              begin
                mpass_r <= mpass_r + 3'h1;
                if (mpass_r == `UVP_MARGIN_PASSES - 1)
                  st_r <= S_END;
                else
                  st_r <= S_SET;
              end
              else
              begin
                mis_r <= {NDEV{1'b0}};
                dev_idx_r <= {NDEV{1'b0}};
                dev_pin_lvl <= {NDEV{`UVP_PIN_IDLE}};
                st_r <= S_VER;
              end
            end
            else
            begin
              img_addr <= img_addr + 13'h0001;
              st_r <= S_SET;
            end
          end
        end
        S_VER:
        begin
          // Read-back, one device enabled at a time
          dev_addr <= img_addr;
          dev_pin_lvl <= {NDEV{`UVP_PIN_IDLE}};
          dev_pin_lvl[2*dev_idx_r +: 2] <= `UVP_PIN_READ;
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == ACC_CYC)
          begin
            cnt_r <= 32'h0;
            st_r <= S_VCHK;
          end
        end
        S_VCHK:
        begin
          dev_pin_lvl <= {NDEV{`UVP_PIN_IDLE}};
          if (sel_r[dev_idx_r] && dq_sync != img_byte(img_data, dev_idx_r))
            mis_r[dev_idx_r] <= 1'b1;
          st_r <= S_VER;
          if (dev_idx_r == NDEV - 1)
          begin
            dev_idx_r <= {NDEV{1'b0}};
            if (img_addr == `UVP_LAST_ADDR)
            begin
              img_addr <= 13'h0000;
              for (i = 0; i < NDEV; i = i + 1)
                dev_pin_lvl[2*i +: 2] <= `UVP_PIN_PROG;
              if (mis_r == {NDEV{1'b0}} &&
                  !(sel_r[dev_idx_r] && dq_sync != img_byte(img_data, dev_idx_r)))
              begin
                margin_r <= 1'b1;
                st_r <= S_SET;
              end
              else if (pass_count >= `UVP_MAX_PASSES)
              begin
                prog_fail <= 1'b1;
                st_r <= S_END;
              end
              else
                st_r <= S_SET;
            end
            else
              img_addr <= img_addr + 13'h0001;
          end
          else
            dev_idx_r <= dev_idx_r + {{(NDEV-1){1'b0}}, 1'b1};
        end
        S_END:
        begin
          dev_dq_oe_n <= 1'b1;
          dev_pin_lvl <= {NDEV{`UVP_PIN_IDLE}};
          prog_done <= 1'b1;
          st_r <= S_IDLE;
        end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end
endmodule // uvp_ctrl

/* verification/uvp_monitor.sv */
// Port checker for the UV EPROM host controller
`timescale 1ns/1ps
module uvp_monitor #(
  parameter NDEV = 1,
  parameter PULSE_CYC = 40000
) (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // User side
  input wire rd_req,
  input wire rd_ready,
  input wire rd_valid,
  // Device pins
  input wire [12:0] dev_addr,
  input wire [7:0] dev_dq_out,
  input wire dev_dq_oe_n,
  input wire [2*NDEV-1:0] dev_pin_lvl
);
  reg [31:0] pw_r;
  reg [15:0] su_r;
  reg [20:0] last_r;
  reg [12:0] pa_r;
  wire pulse_on = (dev_pin_lvl[1:0] == 2'h3);
  // Pulse length, setup age and last pulsed address
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      pw_r <= 32'h0;
      su_r <= 16'h0;
      pa_r <= 13'h1FFF;
    end
    else
    begin
      pw_r <= pulse_on ? pw_r + 32'h1 : 32'h0;
      su_r <= ({dev_addr, dev_dq_out} != last_r) ? 16'h0 : su_r + {15'h0, su_r != 16'hFFFF};
      pa_r <= (pulse_on && pw_r == 32'h0) ? dev_addr : pa_r;
    end
    last_r <= {dev_addr, dev_dq_out};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    rd_req && rd_ready;
  endsequence
  sequence s_active;
    (dev_pin_lvl[1:0] == 2'h0 && dev_dq_oe_n)[*8];
  endsequence
  AST_RD_LAT: assert property (s_taken |-> ##15 rd_valid)
    else $error("read answer late or early");
  AST_RD_ACTIVE: assert property (s_taken |=> s_active)
    else $error("device not held active during read");
  AST_STANDBY: assert property (rd_valid |-> dev_pin_lvl[1:0] == 2'h1)
    else $error("device not returned to standby");
  AST_NO_CONTEND: assert property (dev_pin_lvl[1:0] == 2'h0 |-> dev_dq_oe_n)
    else $error("host drives data while device outputs");
  AST_PULSE_DRV: assert property (pulse_on |-> !dev_dq_oe_n)
    else $error("data not driven during pulse");
  AST_PULSE_STABLE: assert property (pulse_on |-> $stable(dev_addr) && $stable(dev_dq_out))
    else $error("address or data moved during pulse");
  AST_PULSE_WIDTH: assert property ($fell(pulse_on) |-> pw_r == PULSE_CYC)
    else $error("pulse width wrong");
  AST_SETUP: assert property ($rose(pulse_on) |-> su_r >= 16'h0027)
    else $error("setup before pulse too short");
  AST_HOLD: assert property ($fell(pulse_on) |-> (dev_pin_lvl[1:0] == 2'h2)[*2])
    else $error("program level not kept after pulse");
  AST_BLOCK_ORDER: assert property ($rose(pulse_on) |-> dev_addr == pa_r + 13'h1)
    else $error("pulse not at next address");
endmodule // uvp_monitor

bind uvp_ctrl uvp_monitor #(.NDEV(NDEV), .PULSE_CYC(PULSE_CYC)) u_uvp_monitor (
  .clk(clk), .sys_rst(sys_rst), .rd_req(rd_req), .rd_ready(rd_ready), .rd_valid(rd_valid),
  .dev_addr(dev_addr), .dev_dq_out(dev_dq_out), .dev_dq_oe_n(dev_dq_oe_n),
  .dev_pin_lvl(dev_pin_lvl));

/* verification/uvp_eprom_model.sv */
// Behavioural model of the UV EPROM on the device pins
`timescale 1ns/1ps
module uvp_eprom_model (
  // Device pins
  input wire [12:0] dev_addr,
  input wire [7:0] dev_dq_out,
  input wire dev_dq_oe_n,
  input wire [1:0] dev_pin_lvl,
  output wire [7:0] dev_dq,
  // Answer speed
  input wire slow
);
  reg [7:0] mem [0:8191];
  reg [7:0] fpat = 8'hA5, pd = 8'hFF;
  reg [12:0] last_a = 13'h0000, pa = 13'h0000;
  reg [1:0] pl = 2'h1;
  integer age = 0, i;
  // Erased array reads all ones
  initial
  begin
    for (i = 0; i < 8192; i = i + 1)
      mem[i] = 8'hFF;
  end
  // Access timer; a floating bus wanders meanwhile
  always #10
  begin
    age = (dev_pin_lvl != 2'h0 || dev_addr != last_a) ? 0 : age + 10;
    last_a = dev_addr;
    fpat = fpat + 8'h5B;
  end
  // Device drives only when active and its access time is over
  assign dev_dq = !dev_dq_oe_n ? dev_dq_out :
    (dev_pin_lvl == 2'h0 && age >= (slow ? 450 : 60)) ? mem[dev_addr] : fpat;
  // Pulse latches address and data, and clears bits when it ends
  always @(dev_pin_lvl)
  begin
    if (dev_pin_lvl == 2'h3 && pl != 2'h3)
    begin
      pa = dev_addr;
      pd = dev_dq;
    end
    if (pl == 2'h3 && dev_pin_lvl != 2'h3)
      mem[pa] = mem[pa] & pd;
    pl = dev_pin_lvl;
  end
endmodule // uvp_eprom_model

/* verification/tb.sv */
// Self-checking bench for the UV EPROM host controller
`timescale 1ns/1ps
module tb;
  reg clk = 1'b0, sys_rst = 1'b1, rd_req = 1'b0, prog_start = 1'b0, slow = 1'b0;
  reg [12:0] rd_addr = 13'h0000;
  reg [7:0] k1 = 8'h00, k2 = 8'h00, key = 8'h00;
  reg [31:0] rs = 32'h14A4;
  integer n_mismatch = 0, num_checks = 0, i, t;
  wire rd_ready, rd_valid, busy, dq_oe_n, pdone, pfail;
  wire [7:0] rd_data, dq_out, dq_in;
  wire [12:0] img_addr, dev_addr;
  wire [4:0] pass_count;
  wire [1:0] pin_lvl;
  function [7:0] img_fn(input [12:0] a, input [7:0] kk);
    img_fn = a[7:0] ^ {a[12:8], 3'h5} ^ kk;
  endfunction
  function [31:0] xs(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  uvp_ctrl #(.NDEV(1), .PULSE_CYC(8)) u_uvp_ctrl (.clk(clk), .sys_rst(sys_rst),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_sel(1'b1), .rd_ready(rd_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .prog_start(prog_start), .prog_sel(1'b1), .img_addr(img_addr),
    .img_data(img_fn(img_addr, key)), .busy(busy), .prog_done(pdone), .prog_fail(pfail),
    .pass_count(pass_count), .dev_addr(dev_addr), .dev_dq_out(dq_out), .dev_dq_oe_n(dq_oe_n),
    .dev_dq_in(dq_in), .dev_pin_lvl(pin_lvl));
  uvp_eprom_model u_uvp_eprom_model (.dev_addr(dev_addr), .dev_dq_out(dq_out),
    .dev_dq_oe_n(dq_oe_n), .dev_pin_lvl(pin_lvl), .dev_dq(dq_in), .slow(slow));
  // 20 MHz clock
  always #25 clk = ~clk;
  task check(input [31:0] seen, input [31:0] exp, input [79:0] what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task do_reset;
    begin
      @(negedge clk);
      sys_rst = 1'b1;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
    end
  endtask
  // One read; answer speed of the device drawn at random
  task do_read(input [12:0] a, input [7:0] exp);
    begin
      @(negedge clk);
      slow = rs[0];
      rs = xs(rs);
      check(rd_ready, 1, "rd_ready");
      rd_addr = a;
      rd_req = 1'b1;
      @(negedge clk);
      rd_req = 1'b0;
      // Count from the accepting edge, so the first look is cycle one
      t = 1;
      while (rd_valid !== 1'b1 && t < 40)
      begin
        @(negedge clk);
        t = t + 1;
      end
      check(t, 15, "rd_lat");
      check(rd_data, exp, "rd_data");
    end
  endtask
  // Program the first four words of a pass, then abort by reset
  task do_prog(input [7:0] kk);
    begin
      key = kk;
      @(negedge clk);
      prog_start = 1'b1;
      @(negedge clk);
      prog_start = 1'b0;
      t = 0;
      while (dev_addr !== 13'h0004 && t < 2000)
      begin
        @(negedge clk);
        t = t + 1;
      end
      check(pin_lvl, 2'h2, "prog_lvl");
      check(dq_oe_n, 0, "dq_drive");
      check(pass_count, 0, "passes");
      check(busy, 1, "busy");
      check(pfail, 0, "prog_fail");
      check(pdone, 0, "prog_done");
      do_reset;
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // Main sequence: erased reads, two partial jobs, read-back
  initial
  begin
    do_reset;
    for (i = 0; i < 6; i = i + 1)
    begin
      do_read(i < 2 ? {13{i[0]}} : rs[12:0], 8'hFF);
      rs = xs(rs);
    end
    $display("test erased reads done");
    k1 = rs[7:0];
    k2 = rs[15:8];
    do_prog(k1);
    do_prog(k2);
    $display("test program passes done");
    for (i = 0; i < 5; i = i + 1)
      do_read(i, i < 4 ? img_fn(i, k1) & img_fn(i, k2) : 8'hFF);
    $display("test read-back done");
    give_verdict;
  end
  // Watchdog well beyond the expected run of about 930 cycles
  initial
  begin
    #(6000 * 50);
    n_mismatch = n_mismatch + 1;
    give_verdict;
  end
endmodule // tb
